// ===== src/bkr_pkg.sv
// Constants, types and the state record of the step-down regulator register bank.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
package bkr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_EN      = 8'h01;
    localparam logic [7:0] OFS_A_VOUT  = 8'h05;
    localparam logic [7:0] OFS_A_SCALE = 8'h06;
    localparam logic [7:0] OFS_A_CTRL  = 8'h07;
    localparam logic [7:0] OFS_A2_VOUT = 8'h08;
    localparam logic [7:0] OFS_B_VOUT  = 8'h09;
    localparam logic [7:0] OFS_B_SCALE = 8'h0A;
    localparam logic [7:0] OFS_B_CTRL  = 8'h0B;
    localparam logic [7:0] OFS_C       = 8'h0C;
    localparam logic [7:0] OFS_D       = 8'h0D;
    localparam logic [7:0] OFS_PIN     = 8'h0E;
    localparam logic [7:0] OFS_BUCK_FORCE_PULSE_WIDTH    = 8'h0F;
    localparam logic [7:0] OFS_BUCK_FORCE_PULSE_FREQ    = 8'h10;
    localparam logic [7:0] OFS_EILIM   = 8'h11;
    localparam logic [7:0] OFS_PG      = 8'h12;
    localparam logic [7:0] OFS_DLY     = 8'h13;
    // ------------------------------------------------------------
    // Synchroniser lanes and mode codes
    // ------------------------------------------------------------
    localparam int SY_SCL  = 0;
    localparam int SY_SDA  = 1;
    localparam int SY_POWER_ENABLE_PIN_ZERO = 6;
    localparam int SY_POWER_ENABLE_PIN_ONE = 7;
    localparam int SY_PG   = 8;
    localparam int SY_N    = 13;
    localparam logic [1:0] MODE_AUTO = 2'h0;
    localparam logic [1:0] MODE_PWM  = 2'h1;
    localparam logic [1:0] MODE_PFM  = 2'h2;
    localparam logic [3:0] PWIN_LAST = 4'hE;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLEW_STEP_NS  = 1000;
    localparam logic [7:0] SLEW_STEP_CYC = 8'(SLEW_STEP_NS / CLK_PERIOD_NS);
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_WDATA, ST_DACK, ST_RDATA, ST_RACK} bkr_state_e;
    typedef struct packed {
        logic [1:0][5:0] vout;
        logic [1:0][5:0] scale;
        logic [1:0][1:0] sr;
        logic [1:0]      pulse_width_scaling;
        logic [1:0]      dvs;
        logic [5:0]      a2;
        logic [1:0][7:0] cd;
        logic [3:0]      pin;
        logic [3:0]      psel;
        logic [4:0]      buck_force_pulse_width;
        logic [4:0]      buck_force_pulse_freq;
        logic [4:0]      eilim;
        logic [4:0]      pg;
        logic            par;
        logic [1:0]      dly;
        logic [3:0]      en;
    } bkr_regs_s;
    typedef struct packed {
        bkr_state_e      st;
        logic [3:0]      cnt;
        logic [7:0]      shift;
        logic [7:0]      ptr;
        logic            have_ptr;
        logic            rw;
        logic            ack_ok;
        logic            sda_oe;
        logic            boot;
        logic [SY_N-1:0] sy1;
        logic [SY_N-1:0] sy2;
        logic [SY_N-1:0] sy3;
        logic [SY_N-1:0] flt;
        bkr_regs_s       r;
        logic [1:0][5:0] cur;
        logic [1:0][7:0] tick;
        logic [1:0][3:0] pcnt;
        logic [1:0][3:0] pwin;
        logic [1:0][3:0] poff;
        logic [1:0][6:0] code;
        logic [1:0]      rng;
        logic [3:0]      on;
        logic [4:0][1:0] mode;
    } bkr_state_s;
    localparam bkr_state_s RST_STATE = '0;
endpackage

// ===== src/bkr_regs.sv
// Register bank of the four step-down regulators behind an I2C slave port.
// Assumes SCL, SDA, GPIO, enable pins and power-good levels arrive asynchronously.
//
// Notes on behaviour
// [R1] Offsets 0x05..0x13 hold regulator control, one byte each.
// [R2] Scaling-select 1 retargets regulator to its scaling code while on.
// [R3] Two-bit slew field sets step interval between normal and scaling codes.
// [R4] Only regulators A and B have scaling code, select and slew.
// [R5] Pulse-scaling bit adds duty-cycle offset from pin pair to code.
// [R6] Regulator A pulse clock is GPIO4, data GPIO5.
// [R7] Regulator B pulse clock is GPIO3, data GPIO2.
// [R8] A and B codes use external range select, high range default.
// [R9] Software disables a regulator before changing its range.
// [R10] C and D carry two-bit range in bits 7:6 plus six-bit code.
// [R11] Pin-control bit 1 lets an enable pin turn the regulator on.
// [R12] Pin-select bit 0 picks enable pin zero, 1 picks pin one.
// [R13] Pin-control bit 0 leaves power-up to the sequencer.
// [R14] No force bits gives auto mode; single bit forces that mode.
// [R15] Both force bits set gives forced PFM.
// [R16] Lower-limit bit switches lower overcurrent threshold per regulator.
// [R17] Two-bit phase delay field, reset value from fuses.
// [R18] Parallel-phase bit set makes A phases switch together, reset 0.
// [R19] Pin or sequence controlled regulators start enabled; writing 0 disables.
// [R20] Power-good register is read-only, one bit per regulator, reset 0.
// [R21] Unused bits read zero and ignore writes.
`timescale 1ns/100ps
module bkr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h4F
) (
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    input  wire logic [7:0]      gpio_i,
    input  wire logic            power_enable_pin_zero_i,
    input  wire logic            power_enable_pin_one_i,
    input  wire logic [4:0]      power_good_i,
    input  wire logic [3:0]      seq_on_i,
    input  wire logic [3:0]      otp_start_i,
    input  wire logic [3:0]      otp_slew_i,
    input  wire logic [1:0]      otp_dly_i,
    input  wire logic [1:0]      range_high_i,
    output logic [1:0][6:0]      buck_ab_code_o,
    output logic [1:0]           buck_ab_range_high_o,
    output logic [5:0]           buck_a_second_phase_code_o,
    output logic [1:0][7:0]      buck_cd_range_vout_o,
    output logic [3:0]           buck_on_o,
    output logic [4:0][1:0]      buck_mode_o,
    output logic [4:0]           lower_limit_enable_o,
    output logic [1:0]           phase_delay_field_o,
    output logic                 parallel_phase_bit_o
);
    // ------------------------------------------------------------
    // State and combinational helpers
    // ------------------------------------------------------------
    localparam int SY_IN = bkr_pkg::SY_N;
    bkr_pkg::bkr_state_s s_ff;
    bkr_pkg::bkr_state_s nxt_s;
    logic                scl_rise;
    logic                scl_fall;
    logic                start_c;
    logic                stop_c;
    logic                wr_en;
    logic [7:0]          wr_addr;
    logic [7:0]          wr_data;
    logic [7:0]          rd_v;
    logic [SY_IN-1:0]    pin_vec;

    // Read mux; unmapped offsets and unused bits give zero
    function automatic logic [7:0] rd_byte(input bkr_pkg::bkr_regs_s r, input logic [7:0] a);
        case (a)
            bkr_pkg::OFS_EN:      rd_byte = {4'h0, r.en};
            bkr_pkg::OFS_A_VOUT:  rd_byte = {2'h0, r.vout[0]}; // R1
            bkr_pkg::OFS_A_SCALE: rd_byte = {2'h0, r.scale[0]};
            bkr_pkg::OFS_A_CTRL:  rd_byte = {4'h0, r.sr[0], r.pulse_width_scaling[0], r.dvs[0]};
            bkr_pkg::OFS_A2_VOUT: rd_byte = {2'h0, r.a2};
            bkr_pkg::OFS_B_VOUT:  rd_byte = {2'h0, r.vout[1]};
            bkr_pkg::OFS_B_SCALE: rd_byte = {2'h0, r.scale[1]};
            bkr_pkg::OFS_B_CTRL:  rd_byte = {4'h0, r.sr[1], r.pulse_width_scaling[1], r.dvs[1]};
            bkr_pkg::OFS_C:       rd_byte = r.cd[0];
            bkr_pkg::OFS_D:       rd_byte = r.cd[1];
            bkr_pkg::OFS_PIN:     rd_byte = {r.pin, r.psel};
            bkr_pkg::OFS_BUCK_FORCE_PULSE_WIDTH:    rd_byte = {3'h0, r.buck_force_pulse_width};
            bkr_pkg::OFS_BUCK_FORCE_PULSE_FREQ:    rd_byte = {3'h0, r.buck_force_pulse_freq};
            bkr_pkg::OFS_EILIM:   rd_byte = {3'h0, r.eilim};
            bkr_pkg::OFS_PG:      rd_byte = {3'h0, r.pg};
            bkr_pkg::OFS_DLY:     rd_byte = {5'h00, r.par, r.dly};
            default:              rd_byte = 8'h00; // R21
        endcase
    endfunction

    // Asynchronous inputs gathered for the synchroniser
    assign pin_vec = {power_good_i, power_enable_pin_one_i, power_enable_pin_zero_i,
                      gpio_i[5], gpio_i[4], gpio_i[3], gpio_i[2], sda_i, scl_i};

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_s   = s_ff;
        wr_en   = 1'b0;
        wr_addr = 8'h00;
        wr_data = 8'h00;
        rd_v    = rd_byte(s_ff.r, s_ff.ptr);

        // Three-stage synchroniser; a level counts once stages two and three agree
        nxt_s.sy1 = pin_vec;
        nxt_s.sy2 = s_ff.sy1;
        nxt_s.sy3 = s_ff.sy2;
        for (int i = 0; i < SY_IN; i++) begin
            if (s_ff.sy2[i] == s_ff.sy3[i]) begin
                nxt_s.flt[i] = s_ff.sy3[i];
            end
        end

        // Bus events seen on the filtered levels
        scl_rise = !s_ff.flt[bkr_pkg::SY_SCL] && nxt_s.flt[bkr_pkg::SY_SCL];
        scl_fall = s_ff.flt[bkr_pkg::SY_SCL] && !nxt_s.flt[bkr_pkg::SY_SCL];
        start_c  = s_ff.flt[bkr_pkg::SY_SCL] && nxt_s.flt[bkr_pkg::SY_SCL]
                   && s_ff.flt[bkr_pkg::SY_SDA] && !nxt_s.flt[bkr_pkg::SY_SDA];
        stop_c   = s_ff.flt[bkr_pkg::SY_SCL] && nxt_s.flt[bkr_pkg::SY_SCL]
                   && !s_ff.flt[bkr_pkg::SY_SDA] && nxt_s.flt[bkr_pkg::SY_SDA];

        // I2C slave: address, pointer byte, then auto-incrementing data
        if (start_c) begin
            nxt_s.st       = bkr_pkg::ST_ADDR;
            nxt_s.cnt      = 4'h0;
            nxt_s.have_ptr = 1'b0;
            nxt_s.sda_oe   = 1'b0;
        end else if (stop_c) begin
            nxt_s.st     = bkr_pkg::ST_IDLE;
            nxt_s.sda_oe = 1'b0;
        end else begin
            case (s_ff.st)
                bkr_pkg::ST_ADDR, bkr_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        nxt_s.shift = {s_ff.shift[6:0], nxt_s.flt[bkr_pkg::SY_SDA]};
                        nxt_s.cnt   = s_ff.cnt + 4'h1;
                    end else if (scl_fall && s_ff.cnt == 4'h8) begin
                        if (s_ff.st == bkr_pkg::ST_ADDR) begin
                            if (s_ff.shift[7:1] == DEV_ADDR) begin
                                nxt_s.sda_oe = 1'b1;
                                nxt_s.rw     = s_ff.shift[0];
                                nxt_s.st     = bkr_pkg::ST_AACK;
                            end else begin
                                nxt_s.st = bkr_pkg::ST_IDLE;
                            end
                        end else begin
                            nxt_s.sda_oe = 1'b1;
                            nxt_s.st     = bkr_pkg::ST_DACK;
                            if (!s_ff.have_ptr) begin
                                nxt_s.ptr      = s_ff.shift;
                                nxt_s.have_ptr = 1'b1;
                            end else begin
                                wr_en     = 1'b1;
                                wr_addr   = s_ff.ptr;
                                wr_data   = s_ff.shift;
                                nxt_s.ptr = s_ff.ptr + 8'h01;
                            end
                        end
                    end
                end
                bkr_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        nxt_s.cnt = 4'h0;
                        if (s_ff.rw) begin
                            nxt_s.shift  = rd_v;
                            nxt_s.ptr    = s_ff.ptr + 8'h01;
                            nxt_s.sda_oe = !rd_v[7];
                            nxt_s.st     = bkr_pkg::ST_RDATA;
                        end else begin
                            nxt_s.sda_oe = 1'b0;
                            nxt_s.st     = bkr_pkg::ST_WDATA;
                        end
                    end
                end
                bkr_pkg::ST_DACK: begin
                    if (scl_fall) begin
                        nxt_s.sda_oe = 1'b0;
                        nxt_s.cnt    = 4'h0;
                        nxt_s.st     = bkr_pkg::ST_WDATA;
                    end
                end
                bkr_pkg::ST_RDATA: begin
                    // Data changes only while SCL is low; no clock stretching
                    if (scl_fall) begin
                        if (s_ff.cnt == 4'h7) begin
                            nxt_s.sda_oe = 1'b0;
                            nxt_s.st     = bkr_pkg::ST_RACK;
                        end else begin
                            nxt_s.cnt    = s_ff.cnt + 4'h1;
                            nxt_s.shift  = {s_ff.shift[6:0], 1'b0};
                            nxt_s.sda_oe = !s_ff.shift[6];
                        end
                    end
                end
                bkr_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        nxt_s.ack_ok = !nxt_s.flt[bkr_pkg::SY_SDA];
                    end else if (scl_fall) begin
                        if (s_ff.ack_ok) begin
                            nxt_s.cnt    = 4'h0;
                            nxt_s.shift  = rd_v;
                            nxt_s.ptr    = s_ff.ptr + 8'h01;
                            nxt_s.sda_oe = !rd_v[7];
                            nxt_s.st     = bkr_pkg::ST_RDATA;
                        end else begin
                            nxt_s.st = bkr_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    nxt_s.sda_oe = 1'b0;
                end
            endcase
        end

        // Register writes; only defined field bits are stored
        if (wr_en) begin
            case (wr_addr)
                bkr_pkg::OFS_EN:      nxt_s.r.en = wr_data[3:0]; // R19
                bkr_pkg::OFS_A_VOUT:  nxt_s.r.vout[0] = wr_data[5:0]; // R1
                bkr_pkg::OFS_A_SCALE: nxt_s.r.scale[0] = wr_data[5:0]; // R4
                bkr_pkg::OFS_A_CTRL: begin
                    nxt_s.r.sr[0]   = wr_data[3:2]; // R3
                    nxt_s.r.pulse_width_scaling[0] = wr_data[1];
                    nxt_s.r.dvs[0]  = wr_data[0];
                end
                bkr_pkg::OFS_A2_VOUT: nxt_s.r.a2 = wr_data[5:0];
                bkr_pkg::OFS_B_VOUT:  nxt_s.r.vout[1] = wr_data[5:0];
                bkr_pkg::OFS_B_SCALE: nxt_s.r.scale[1] = wr_data[5:0];
                bkr_pkg::OFS_B_CTRL: begin
                    nxt_s.r.sr[1]   = wr_data[3:2];
                    nxt_s.r.pulse_width_scaling[1] = wr_data[1];
                    nxt_s.r.dvs[1]  = wr_data[0];
                end
                bkr_pkg::OFS_C:       nxt_s.r.cd[0] = wr_data; // R10
                bkr_pkg::OFS_D:       nxt_s.r.cd[1] = wr_data;
                bkr_pkg::OFS_PIN: begin
                    nxt_s.r.pin  = wr_data[7:4];
                    nxt_s.r.psel = wr_data[3:0];
                end
                bkr_pkg::OFS_BUCK_FORCE_PULSE_WIDTH:    nxt_s.r.buck_force_pulse_width = wr_data[4:0];
                bkr_pkg::OFS_BUCK_FORCE_PULSE_FREQ:    nxt_s.r.buck_force_pulse_freq = wr_data[4:0];
                bkr_pkg::OFS_EILIM:   nxt_s.r.eilim = wr_data[4:0]; // R16
                bkr_pkg::OFS_DLY: begin
                    nxt_s.r.par = wr_data[2]; // R18
                    nxt_s.r.dly = wr_data[1:0];
                end
                default: ; // R21
            endcase
        end

        // Power-good follows the pins, so writes to it never stick
        nxt_s.r.pg = s_ff.flt[bkr_pkg::SY_PG +: 5]; // R20

        // First cycle after reset loads the fuse image
        if (!s_ff.boot) begin
            nxt_s.boot    = 1'b1;
            nxt_s.r.en    = otp_start_i; // R19
            nxt_s.r.sr[0] = otp_slew_i[1:0];
            nxt_s.r.sr[1] = otp_slew_i[3:2];
            nxt_s.r.dly   = otp_dly_i; // R17
        end

        // Scaling regulators: ramp one code per slew interval toward the target
        for (int i = 0; i < 2; i++) begin
            logic [5:0] tgt;
            logic [3:0] ones;
            logic       pclk_rise;
            logic       pdat;
            tgt       = s_ff.r.dvs[i] ? s_ff.r.scale[i] : s_ff.r.vout[i]; // R2
            pclk_rise = (i == 0) ? (!s_ff.flt[4] && nxt_s.flt[4]) : (!s_ff.flt[3] && nxt_s.flt[3]); // R6 R7
            pdat      = (i == 0) ? s_ff.flt[5] : s_ff.flt[2];
            ones      = s_ff.pcnt[i] + {3'h0, pdat};
            if (s_ff.cur[i] == tgt) begin
                nxt_s.tick[i] = 8'h00;
            end else if (s_ff.tick[i] == 8'h00) begin
                nxt_s.cur[i]  = (tgt > s_ff.cur[i]) ? s_ff.cur[i] + 6'h01 : s_ff.cur[i] - 6'h01;
                nxt_s.tick[i] = 8'(bkr_pkg::SLEW_STEP_CYC << s_ff.r.sr[i]) - 8'h01; // R3
            end else begin
                nxt_s.tick[i] = s_ff.tick[i] - 8'h01;
            end
            // Duty cycle counted as data-high samples over a fifteen-edge window
            if (!s_ff.r.pulse_width_scaling[i]) begin
                nxt_s.pcnt[i] = 4'h0;
                nxt_s.pwin[i] = 4'h0;
                nxt_s.poff[i] = 4'h0;
            end else if (pclk_rise) begin
                if (s_ff.pwin[i] == bkr_pkg::PWIN_LAST) begin
                    nxt_s.poff[i] = ones; // R5
                    nxt_s.pcnt[i] = 4'h0;
                    nxt_s.pwin[i] = 4'h0;
                end else begin
                    nxt_s.pcnt[i] = ones;
                    nxt_s.pwin[i] = s_ff.pwin[i] + 4'h1;
                end
            end
            nxt_s.code[i] = {1'b0, s_ff.cur[i]} + {3'h0, s_ff.poff[i]}; // R5
        end
        nxt_s.rng = range_high_i; // R8

        // Enable path: pin control or sequencer, always gated by the enable bit
        for (int j = 0; j < 4; j++) begin
            if (s_ff.r.pin[j]) begin
                nxt_s.on[j] = s_ff.r.en[j] && (s_ff.r.psel[j] ? s_ff.flt[bkr_pkg::SY_POWER_ENABLE_PIN_ONE]
                                                               : s_ff.flt[bkr_pkg::SY_POWER_ENABLE_PIN_ZERO]); // R11 R12
            end else begin
                nxt_s.on[j] = s_ff.r.en[j] && seq_on_i[j]; // R13
            end
        end

        // Forced mode; PFM wins when both bits are set
        for (int k = 0; k < 5; k++) begin
            if (s_ff.r.buck_force_pulse_freq[k]) begin
                nxt_s.mode[k] = bkr_pkg::MODE_PFM; // R15
            end else if (s_ff.r.buck_force_pulse_width[k]) begin
                nxt_s.mode[k] = bkr_pkg::MODE_PWM; // R14
            end else begin
                nxt_s.mode[k] = bkr_pkg::MODE_AUTO;
            end
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_ff <= bkr_pkg::RST_STATE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // SDA is open drain: only a low is ever driven
    assign sda_o                      = 1'b0;
    assign sda_oe_o                   = s_ff.sda_oe;
    assign buck_ab_code_o             = s_ff.code;
    assign buck_ab_range_high_o       = s_ff.rng;
    assign buck_a_second_phase_code_o = s_ff.r.a2;
    assign buck_cd_range_vout_o       = s_ff.r.cd;
    assign buck_on_o                  = s_ff.on;
    assign buck_mode_o                = s_ff.mode;
    assign lower_limit_enable_o       = s_ff.r.eilim;
    assign phase_delay_field_o        = s_ff.r.dly;
    assign parallel_phase_bit_o       = s_ff.r.par;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    reg_write_a: assert property (wr_en && wr_addr == bkr_pkg::OFS_B_VOUT |=> s_ff.r.vout[1] == $past(wr_data[5:0])) // R1
        else $error("vout write lost");
    dvs_ramp_a: assert property (s_ff.r.dvs[0] && s_ff.r.scale[0] < s_ff.cur[0] && s_ff.tick[0] == 8'h00
        |=> s_ff.cur[0] == $past(s_ff.cur[0]) - 6'h01) // R2
        else $error("no step toward scaling code");
    slew_step_a: assert property ($changed(s_ff.cur[1]) |-> s_ff.cur[1] == $past(s_ff.cur[1]) + 6'h01
        || s_ff.cur[1] == $past(s_ff.cur[1]) - 6'h01) // R3
        else $error("code jumped more than one step");
    pulse_width_scaling_off_a: assert property ((!s_ff.r.pulse_width_scaling[0])[*3] |-> buck_ab_code_o[0] == {1'b0, $past(s_ff.cur[0])}) // R5
        else $error("offset present while pulse scaling off");
    pin_on_a: assert property (s_ff.r.pin[1] && s_ff.r.en[1] && !s_ff.r.psel[1] && s_ff.flt[bkr_pkg::SY_POWER_ENABLE_PIN_ZERO]
        |=> buck_on_o[1]) // R11
        else $error("pin enable ignored");
    seq_off_a: assert property (!s_ff.r.pin[1] && !seq_on_i[1] |=> !buck_on_o[1]) // R13
        else $error("on without sequencer");
    mode_auto_a: assert property (!s_ff.r.buck_force_pulse_width[1] && !s_ff.r.buck_force_pulse_freq[1] |=> buck_mode_o[1] == bkr_pkg::MODE_AUTO) // R14
        else $error("auto mode missing");
    pfm_wins_a: assert property (s_ff.r.buck_force_pulse_width[0] && s_ff.r.buck_force_pulse_freq[0] |=> buck_mode_o[0] == bkr_pkg::MODE_PFM) // R15
        else $error("both bits not PFM");
    pg_track_a: assert property (s_ff.boot |-> ##1 s_ff.r.pg == $past(s_ff.flt[bkr_pkg::SY_PG +: 5])) // R20
        else $error("power good not tracking");
    boot_en_a: assert property (rst_b_i && !s_ff.boot |=> s_ff.r.en == $past(otp_start_i)) // R19
        else $error("start enable not loaded");

    read_ack_c: cover property (s_ff.st == bkr_pkg::ST_RACK ##1 s_ff.st == bkr_pkg::ST_RDATA);
    reg_wr_c:   cover property (wr_en && wr_addr == bkr_pkg::OFS_A_CTRL);
    dvs_done_c: cover property (s_ff.r.dvs[0] && $changed(s_ff.cur[0]) ##1 s_ff.cur[0] == s_ff.r.scale[0]);
    pwin_c:     cover property (s_ff.poff[1] != 4'h0);
endmodule

// ===== sim/bkr_i2c_master.sv
// Two-wire bus master model facing the regulator register bank.
// Assumes SDA is open drain with a pull-up, so a released wire reads 1.
`timescale 1ns/100ps
module bkr_i2c_master (
    input  wire logic clk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic sda_m = 1'b1;
    initial scl_o = 1'b1;
    // Wired-AND of master and bank on the pulled-up data line
    assign sda_o = sda_m & ~sda_oe_i;
    // Nine bits MSB first; SDA moves only while SCL is low
    task automatic xfer(input logic [8:0] v, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            sda_m <= v[i];
            repeat (6) @(posedge clk_i);
            scl_o <= 1'b1;
            repeat (8) @(posedge clk_i);
            r[i] = sda_o;
            scl_o <= 1'b0;
            repeat (6) @(posedge clk_i);
        end
    endtask
    // START when stop is 0, STOP when 1; phases long enough for the filter
    task automatic cond(input logic stop);
        sda_m <= ~stop;
        repeat (6) @(posedge clk_i);
        scl_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        sda_m <= stop;
        repeat (8) @(posedge clk_i);
        scl_o <= stop;
        repeat (6) @(posedge clk_i);
    endtask
    // Write one byte: address, pointer, data
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic [8:0] r;
        cond(1'b0);
        xfer({8'h9E, 1'b1}, r);
        xfer({ofs, 1'b1}, r);
        xfer({d, 1'b1}, r);
        cond(1'b1);
    endtask
    // Combined read: pointer, repeated START, one byte, NACK
    task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
        logic [8:0] r;
        cond(1'b0);
        xfer({8'h9E, 1'b1}, r);
        xfer({ofs, 1'b1}, r);
        cond(1'b0);
        xfer({8'h9F, 1'b1}, r);
        xfer(9'h1FF, r);
        d = r[8:1];
        cond(1'b1);
    endtask
endmodule

// ===== sim/tb_bkr_regs.sv
// Self-checking bench of the regulator register bank over its two-wire port.
// Assumes the master model in bkr_i2c_master and the default device address.
`timescale 1ns/100ps
module tb_bkr_regs;
    logic clk_i = 1'b0, rst_b_i = 1'b0, power_enable_pin_zero = 1'b1, power_enable_pin_one = 1'b0, scl_i, sda_i, sda_oe_o, parallel_phase_bit_o;
    logic [3:0] seq_on = 4'h0, buck_on_o;
    logic [7:0] rdv, gpio = 8'h00;
    logic [1:0] buck_ab_range_high_o, phase_delay_field_o;
    logic [1:0][6:0] buck_ab_code_o;
    logic [1:0][7:0] buck_cd_range_vout_o;
    logic [4:0][1:0] buck_mode_o;
    logic [4:0] lower_limit_enable_o;
    int num_errors = 0, samples_checked = 0;
    // Offset, written byte, expected read-back
    localparam logic [23:0] ROWS [16] = '{24'h05FF3F, 24'h062A2A, 24'h07FF0F, 24'h08FF3F, 24'h092A2A, 24'h0AFF3F,
        24'h0BFF0F, 24'h0CC5C5, 24'h0D7E7E, 24'h0EA5A5, 24'h0FFF1F, 24'h10FF1F, 24'h11FF1F, 24'h12FF15,
        24'h13FF07, 24'h20FF00};
    always #50 clk_i = ~clk_i;
    bkr_regs u_bkr_regs (.clk_i, .rst_b_i, .scl_i, .sda_i, .sda_o(), .sda_oe_o, .gpio_i(gpio),
        .power_enable_pin_zero_i(power_enable_pin_zero), .power_enable_pin_one_i(power_enable_pin_one), .power_good_i(5'h15), .seq_on_i(seq_on),
        .otp_start_i(4'hF), .otp_slew_i(4'h0), .otp_dly_i(2'h2), .range_high_i(2'h1), .buck_ab_code_o,
        .buck_ab_range_high_o, .buck_a_second_phase_code_o(), .buck_cd_range_vout_o, .buck_on_o, .buck_mode_o,
        .lower_limit_enable_o, .phase_delay_field_o, .parallel_phase_bit_o);
    bkr_i2c_master u_bkr_i2c_master (.clk_i, .sda_oe_i(sda_oe_o), .scl_o(scl_i), .sda_o(sda_i));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Ramp is slow, so the wait is bounded and a miss is a mismatch
    task automatic wait_code(input logic [6:0] exp);
        for (int i = 0; i < 2000 && buck_ab_code_o[0] !== exp; i++) @(posedge clk_i);
        chk("code a", 16'(buck_ab_code_o[0]), 16'(exp));
    endtask
    task automatic wrap_up;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence: reset, table of registers, then mode, enable and scaling cases
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk("mode reset", 16'(buck_mode_o), 16'h0000);
        u_bkr_i2c_master.rd(8'h01, rdv);
        chk("enable start", 16'(rdv), 16'h000F);
        u_bkr_i2c_master.rd(8'h13, rdv);
        chk("delay fuse", 16'(rdv), 16'h0002);
        u_bkr_i2c_master.wr(8'h01, 8'h00);
        for (int i = 0; i < 16; i++) begin
            u_bkr_i2c_master.wr(ROWS[i][23:16], ROWS[i][15:8]);
            u_bkr_i2c_master.rd(ROWS[i][23:16], rdv);
            chk("register", 16'(rdv), 16'(ROWS[i][7:0]));
        end
        u_bkr_i2c_master.wr(8'h01, 8'h0F);
        chk("cd out", 16'(buck_cd_range_vout_o), 16'h7EC5);
        chk("limit", 16'(lower_limit_enable_o), 16'h001F);
        chk("both forced", 16'(buck_mode_o), 16'h02AA);
        chk("phase", 16'({parallel_phase_bit_o, phase_delay_field_o}), 16'h0007);
        chk("range", 16'(buck_ab_range_high_o), 16'h0001);
        u_bkr_i2c_master.wr(8'h10, 8'h00);
        chk("forced pwm", 16'(buck_mode_o), 16'h0155);
        u_bkr_i2c_master.wr(8'h0F, 8'h00);
        chk("auto", 16'(buck_mode_o), 16'h0000);
        chk("pin zero", 16'(buck_on_o), 16'h000A);
        power_enable_pin_zero <= 1'b0;
        power_enable_pin_one <= 1'b1;
        seq_on <= 4'hA;
        u_bkr_i2c_master.wr(8'h0E, 8'h5F);
        chk("pin one", 16'(buck_on_o), 16'h000F);
        u_bkr_i2c_master.wr(8'h01, 8'h00);
        chk("disable", 16'(buck_on_o), 16'h0000);
        u_bkr_i2c_master.wr(8'h07, 8'h01);
        wait_code(7'h2A);
        u_bkr_i2c_master.wr(8'h07, 8'h00);
        wait_code(7'h3F);
        // Pulse scaling on A: data high over a full window of companion clocks
        u_bkr_i2c_master.wr(8'h07, 8'h02);
        for (int i = 0; i < 32; i++) begin
            gpio <= {2'h0, 1'b1, i[0], 4'h0};
            repeat (6) @(posedge clk_i);
        end
        wait_code(7'h4E);
        chk("code b", 16'(buck_ab_code_o[1]), 16'h003F);
        wrap_up();
    end
endmodule
